/* shared/fpr_pkg.sv */
// constants and types shared by the front-panel reset/abort/status block
package fpr_pkg;
  // board clock
  localparam int unsigned CLK_KHZ = 25_000;
  localparam int unsigned CLK_HZ  = CLK_KHZ * 1000;

  // times in their own units and derived cycle counts
  localparam int unsigned SYSRESET_MIN_MS = 200;
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned LOCAL_RESET_MS  = 1;
  localparam logic [22:0] SYSRESET_CYCLES = 23'(SYSRESET_MIN_MS * CLK_KHZ);
  localparam logic [17:0] DEBOUNCE_CYCLES = 18'(DEBOUNCE_MS * CLK_KHZ);
  localparam logic [19:0] LOCAL_CYCLES    = 20'(LOCAL_RESET_MS * CLK_KHZ);

  // console framing at power-up
  localparam int unsigned BAUD_POWERUP = 9600;
  localparam logic [15:0] UART_DIV_RST =
    16'((CLK_HZ + 8 * BAUD_POWERUP) / (16 * BAUD_POWERUP));
  // [4]=sync mode (never), [3]=parity on, [2]=two stop, [1:0]=8 data bits
  localparam logic [4:0]  UART_FIXED   = 5'h03;

  // apb register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STAT   = 8'h04;
  localparam logic [7:0] REG_MASK   = 8'h08;
  localparam logic [7:0] REG_INPUTS = 8'h0c;
  localparam logic [7:0] REG_UART   = 8'h10;

  // control register fields
  localparam int unsigned CTL_ABORT_EN  = 0;
  localparam int unsigned CTL_LEVEL_LSB = 1;
  localparam int unsigned CTL_SYSRST    = 5;
  localparam int unsigned CTL_LOC_HOLD  = 6;

  // status / mask bits
  localparam int unsigned EV_ABORT  = 0;
  localparam int unsigned EV_SYSIN  = 1;
  localparam int unsigned EV_WDOG   = 2;
  localparam int unsigned EV_BUTTON = 3;
  localparam int unsigned UART_FIX_LSB = 16;

  // synchroniser lanes and their idle levels
  localparam int unsigned SY_ABORT = 0;
  localparam int unsigned SY_RSTBTN = 1;
  localparam int unsigned SY_WDOG = 2;
  localparam int unsigned SY_SYSIN = 3;
  localparam int unsigned SY_SYSCTRL = 4;
  localparam int unsigned SY_BFAIL = 5;
  localparam int unsigned SY_BUSY = 6;
  localparam int unsigned SY_GNT1 = 7;
  localparam int unsigned SY_GNT2 = 8;
  localparam int unsigned SY_CARRIER = 9;
  localparam logic [9:0]  SYNC_IDLE = 10'h1eb;
  localparam logic [1:0]  PU_START  = 2'h3;

  // abort debounce states, gray along idle-press-held-release
  typedef enum logic [1:0] {
    DB_IDLE  = 2'b00,
    DB_PRESS = 2'b01,
    DB_HELD  = 2'b11,
    DB_REL   = 2'b10
  } fpr_db_t;
endpackage : fpr_pkg

/* src/fpr_front_panel.sv */
// front panel abort, reset sequencing, lamps and console framing
//
// Function
// - enabled abort press interrupts at programmed level
// - abort interrupt delivered on isa irq8
// - abort button state readable for polling
// - abort is debounced and edge triggered
// - reset button resets board and processor
// - button drives sysreset only as controller
// - four sources assert sysreset as controller
// - sysreset held at least 200 ms
// - software bit holds board in reset
// - local reset works without controller role
// - five sources generate local reset
// - fail lamp follows board fail line
// - cpu lamp follows processor bus busy
// - slot lamps follow their pci grants
// - carrier lamps lit in reset, else mastership
// - console powers up 8n1 at 9600
// - console port is asynchronous only
`timescale 1ns/1ps
module fpr_front_panel
  import fpr_pkg::*;
#(
  parameter logic [22:0] SYSRST_HOLD  = SYSRESET_CYCLES,
  parameter logic [17:0] DEBOUNCE_LEN = DEBOUNCE_CYCLES,
  parameter logic [19:0] LOCAL_HOLD   = LOCAL_CYCLES
) (
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_abort_button_n,
  input  wire logic        i_reset_button_n,
  input  wire logic        i_watchdog_timeout,
  input  wire logic        i_sysreset_in_n,
  input  wire logic        i_system_controller,
  input  wire logic        i_expansion_carrier,
  input  wire logic        i_board_fail_line_n,
  input  wire logic        i_processor_bus_busy_n,
  input  wire logic        i_pci_grant1_n,
  input  wire logic        i_pci_grant2_n,
  output logic             o_sysreset_out,
  output logic             o_sysreset_oe,
  output logic             o_local_reset_n,
  output logic             o_processor_hard_reset_n,
  output logic             o_isa_irq8,
  output logic      [3:0]  o_abort_level,
  output logic             o_irq,
  output logic             o_board_fail_lamp,
  output logic             o_cpu_lamp,
  output logic             o_mezzanine_slot1_lamp,
  output logic             o_mezzanine_slot2_lamp,
  output logic      [15:0] o_uart_divisor,
  output logic      [4:0]  o_uart_format
);

  typedef struct packed {
    logic [9:0]  sync1;
    logic [9:0]  sync2;
    fpr_db_t     db_state;
    logic [17:0] db_cnt;
    logic        abort_en;
    logic [3:0]  abort_level;
    logic        loc_hold;
    logic        sysrst_req;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic [15:0] uart_div;
    logic [1:0]  pu_cnt;
    logic [22:0] sys_cnt;
    logic [19:0] loc_cnt;
    logic        sys_drive;
    logic        loc_act;
    logic        wd_prev;
    logic        sysin_prev;
    logic        btn_prev;
    logic        irq8;
    logic        irq;
    logic [3:0]  lamps;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fpr_state_t;

  localparam fpr_state_t STATE_RST = '{
    sync1: SYNC_IDLE, sync2: SYNC_IDLE, db_state: DB_IDLE,
    abort_level: 4'h0, uart_div: UART_DIV_RST, pu_cnt: PU_START,
    loc_cnt: LOCAL_HOLD, loc_act: 1'b1, default: '0
  };

  fpr_state_t s;
  fpr_state_t next_s;

  // one compare function used by the read and write decoders
  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    return a == off;
  endfunction : reg_hit

  logic       press_evt;
  logic       db_pressed;
  logic       btn;
  logic       wdog;
  logic       sysin;
  logic       sysctrl;
  logic       pu_src;
  logic       wr_acc;
  logic       rd_acc;
  logic [3:0] ev_set;
  logic [3:0] ev_clr;

  always_comb begin
    next_s = s;
    next_s.sync1 = {i_expansion_carrier, i_pci_grant2_n, i_pci_grant1_n,
                    i_processor_bus_busy_n, i_board_fail_line_n,
                    i_system_controller, i_sysreset_in_n,
                    i_watchdog_timeout, i_reset_button_n,
                    i_abort_button_n};
    next_s.sync2 = s.sync1;
    next_s.sysrst_req = 1'b0;
    press_evt = 1'b0;

    case (s.db_state)
      DB_IDLE: begin
        next_s.db_cnt = '0;
        if (!s.sync2[SY_ABORT]) begin
          next_s.db_state = DB_PRESS;
        end
      end
      DB_PRESS: begin
        if (s.sync2[SY_ABORT]) begin
          next_s.db_state = DB_IDLE;
        end else if (s.db_cnt == DEBOUNCE_LEN - 18'h1) begin
          next_s.db_state = DB_HELD;
          press_evt = 1'b1;
        end else begin
          next_s.db_cnt = s.db_cnt + 18'h1;
        end
      end
      // held button waits for a clean release
      DB_HELD: begin
        next_s.db_cnt = '0;
        if (s.sync2[SY_ABORT]) begin
          next_s.db_state = DB_REL;
        end
      end
      DB_REL: begin
        if (!s.sync2[SY_ABORT]) begin
          next_s.db_state = DB_HELD;
          next_s.db_cnt = '0;
        end else if (s.db_cnt == DEBOUNCE_LEN - 18'h1) begin
          next_s.db_state = DB_IDLE;
        end else begin
          next_s.db_cnt = s.db_cnt + 18'h1;
        end
      end
      default: begin
        next_s.db_state = DB_IDLE;
      end
    endcase
    db_pressed = (s.db_state == DB_HELD) || (s.db_state == DB_REL);

    btn     = !s.sync2[SY_RSTBTN];
    wdog    = s.sync2[SY_WDOG];
    sysin   = !s.sync2[SY_SYSIN];
    sysctrl = s.sync2[SY_SYSCTRL];
    // power-up source fires once the straps have crossed the synchroniser
    pu_src  = (s.pu_cnt == 2'h1);
    if (s.pu_cnt != 2'h0) begin
      next_s.pu_cnt = s.pu_cnt - 2'h1;
    end
    next_s.wd_prev    = wdog;
    next_s.sysin_prev = sysin;
    next_s.btn_prev   = btn;

    if (sysctrl && (btn || pu_src || wdog || s.sysrst_req)) begin
      next_s.sys_cnt = SYSRST_HOLD;
    end else if (s.sys_cnt != '0) begin
      next_s.sys_cnt = s.sys_cnt - 23'h1;
    end
    next_s.sys_drive = (next_s.sys_cnt != '0) && sysctrl;

    if (btn || pu_src || wdog || sysin) begin
      next_s.loc_cnt = LOCAL_HOLD;
    end else if (s.loc_cnt != '0) begin
      next_s.loc_cnt = s.loc_cnt - 20'h1;
    end

    // apb: access phase answers one cycle after it opens
    wr_acc = i_psel && i_penable && s.pready && i_pwrite && !s.pslverr;
    rd_acc = i_psel && i_penable && s.pready && !i_pwrite;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    if (i_psel && i_penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = '0;
      if (reg_hit(i_paddr, REG_CTRL)) begin
        next_s.prdata[CTL_ABORT_EN] = s.abort_en;
        next_s.prdata[CTL_LEVEL_LSB +: 4] = s.abort_level;
        next_s.prdata[CTL_LOC_HOLD] = s.loc_hold;
      end else if (reg_hit(i_paddr, REG_STAT)) begin
        next_s.prdata[3:0] = s.stat;
      end else if (reg_hit(i_paddr, REG_MASK)) begin
        next_s.prdata[3:0] = s.mask;
      end else if (reg_hit(i_paddr, REG_INPUTS)) begin
        next_s.prdata[0] = db_pressed;
        next_s.prdata[1] = sysctrl;
        next_s.prdata[2] = s.sys_drive;
        next_s.prdata[3] = s.loc_act;
        next_s.prdata[4] = s.sync2[SY_CARRIER];
      end else if (reg_hit(i_paddr, REG_UART)) begin
        next_s.prdata[15:0] = s.uart_div;
        next_s.prdata[UART_FIX_LSB +: 5] = UART_FIXED;
      end else begin
        next_s.pslverr = 1'b1;
      end
    end

    if (wr_acc) begin
      if (reg_hit(i_paddr, REG_CTRL)) begin
        next_s.abort_en = i_pwdata[CTL_ABORT_EN];
        next_s.abort_level = i_pwdata[CTL_LEVEL_LSB +: 4];
        next_s.sysrst_req = i_pwdata[CTL_SYSRST];
        next_s.loc_hold = i_pwdata[CTL_LOC_HOLD];
      end else if (reg_hit(i_paddr, REG_MASK)) begin
        next_s.mask = i_pwdata[3:0];
      end else if (reg_hit(i_paddr, REG_UART)) begin
        // baud may be reprogrammed after power-up
        next_s.uart_div = i_pwdata[15:0];
      end
    end

    // software hold keeps the board in reset
    next_s.loc_act = (next_s.loc_cnt != '0) || next_s.loc_hold;

    // press sets pending only when enabled
    ev_set = '0;
    ev_set[EV_ABORT]  = press_evt && s.abort_en;
    ev_set[EV_SYSIN]  = sysin && !s.sysin_prev;
    ev_set[EV_WDOG]   = wdog && !s.wd_prev;
    ev_set[EV_BUTTON] = btn && !s.btn_prev;
    // only the bits actually reported are cleared, so a late event survives
    ev_clr = (rd_acc && reg_hit(i_paddr, REG_STAT)) ? s.prdata[3:0] : '0;
    next_s.stat = (s.stat & ~ev_clr) | ev_set;
    next_s.irq  = |(next_s.stat & next_s.mask);
    next_s.irq8 = next_s.stat[EV_ABORT] && next_s.abort_en;

    next_s.lamps[0] = !s.sync2[SY_BFAIL];
    next_s.lamps[1] = !s.sync2[SY_BUSY];
    next_s.lamps[2] = !s.sync2[SY_GNT1] ||
                      (s.sync2[SY_CARRIER] && s.loc_act);
    next_s.lamps[3] = !s.sync2[SY_GNT2] ||
                      (s.sync2[SY_CARRIER] && s.loc_act);
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign o_prdata  = s.prdata;
  assign o_pready  = s.pready;
  assign o_pslverr = s.pslverr;
  // open drain: the pin is only ever pulled low
  assign o_sysreset_out = s.sysrst_req & 1'b0;
  assign o_sysreset_oe  = s.sys_drive;
  // local reset independent of controller role
  assign o_local_reset_n          = !s.loc_act;
  assign o_processor_hard_reset_n = !s.loc_act;
  assign o_isa_irq8    = s.irq8;
  assign o_abort_level = s.abort_level;
  assign o_irq         = s.irq;
  assign o_board_fail_lamp      = s.lamps[0];
  assign o_cpu_lamp             = s.lamps[1];
  assign o_mezzanine_slot1_lamp = s.lamps[2];
  assign o_mezzanine_slot2_lamp = s.lamps[3];
  assign o_uart_divisor = s.uart_div;
  assign o_uart_format  = UART_FIXED;

  // checking helpers
  logic [22:0] hold_cnt;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      hold_cnt <= '0;
    end else if (!o_sysreset_oe) begin
      hold_cnt <= '0;
    end else if (hold_cnt != '1) begin
      hold_cnt <= hold_cnt + 23'h1;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  sequence seq_apb_rd(logic [7:0] off);
    i_psel && i_penable && !s.pready && !i_pwrite && i_paddr == off
    ##1 o_pready;
  endsequence

  sequence seq_press_held;
    press_evt ##1 (s.db_state == DB_HELD);
  endsequence

  a_abort_press_irq: assert property (
    (press_evt && s.abort_en && !wr_acc) |=> (s.stat[EV_ABORT] && o_isa_irq8))
    else $error("enabled abort press did not raise irq8");
  a_irq8_cause: assert property (
    o_isa_irq8 |-> (s.stat[EV_ABORT] && s.abort_en))
    else $error("irq8 high without enabled pending abort");
  a_abort_poll: assert property (
    seq_apb_rd(REG_INPUTS) |-> o_prdata[0] == $past(db_pressed))
    else $error("abort state read back wrong");
  a_abort_filter: assert property (
    press_evt |-> (s.db_cnt == DEBOUNCE_LEN - 18'h1)
                  && $past(!s.sync2[SY_ABORT]))
    else $error("abort press accepted before debounce");
  a_no_retrigger: assert property (
    seq_press_held |=> (!press_evt)[*8])
    else $error("held abort retriggered");
  a_button_reset: assert property (
    btn |=> (!o_processor_hard_reset_n && !o_local_reset_n))
    else $error("reset button failed to reset board");
  a_sysrst_role: assert property (
    o_sysreset_oe |-> $past(sysctrl))
    else $error("sysreset driven while not controller");
  a_sysrst_src: assert property (
    (sysctrl && (btn || wdog || s.sysrst_req)) |=> o_sysreset_oe)
    else $error("sysreset source ignored");
  a_sysrst_hold: assert property (
    ($fell(o_sysreset_oe) && sysctrl && $past(sysctrl))
      |-> $past(hold_cnt) >= SYSRST_HOLD - 23'h1)
    else $error("sysreset released early");
  a_local_hold: assert property (
    s.loc_hold |-> !o_local_reset_n)
    else $error("software hold did not keep local reset");
  a_sysin_local: assert property (
    (sysin && !sysctrl) |=> !o_local_reset_n)
    else $error("incoming sysreset missed local reset");
  a_lamp_follow: assert property (
    ##1 (o_board_fail_lamp == $past(!s.sync2[SY_BFAIL])
         && o_cpu_lamp == $past(!s.sync2[SY_BUSY])))
    else $error("fail or cpu lamp wrong");
  a_carrier_lamps: assert property (
    (s.sync2[SY_CARRIER] && s.loc_act)
      |=> (o_mezzanine_slot1_lamp && o_mezzanine_slot2_lamp))
    else $error("carrier lamps dark during reset");
  a_slot_grant: assert property (
    (!s.sync2[SY_GNT1] && !s.sync2[SY_GNT2])
      |=> (o_mezzanine_slot1_lamp && o_mezzanine_slot2_lamp))
    else $error("slot lamp dark while granted");
  a_uart_format: assert property (
    seq_apb_rd(REG_UART) |-> o_prdata[UART_FIX_LSB +: 5] == UART_FIXED)
    else $error("console framing not 8n1 async");
endmodule : fpr_front_panel

/* verif/fpr_backplane.sv */
// backplane side: open-drain system reset wire with its pull-up
`timescale 1ns/1ps
module fpr_backplane (
  input  wire logic i_sysreset_oe,
  input  wire logic i_sysreset_out,
  input  wire logic i_other_assert,
  output logic      o_sysreset_n
);
  // wire-or of drivers
  // pulled high unless this board or another board pulls it low
  assign o_sysreset_n = !((i_sysreset_oe && !i_sysreset_out) ||
                          i_other_assert);
endmodule : fpr_backplane

/* verif/fpr_front_panel_test.sv */
// self-checking bench for the front-panel reset/abort/lamp block
`timescale 1ns/1ps
module fpr_front_panel_test;
  import fpr_pkg::*;
  localparam logic [22:0] HOLD = 23'd40;
  logic        i_mclk, i_nrst, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, oe, oe_seen, sys_n, other;
  logic        abort_n, btn_n, wdog, ctl, carrier, fail_n, busy_n, g1_n, g2_n;
  logic        sys_out, loc_n, hard_n, irq8, irq, l_fail, l_cpu, l_s1, l_s2;
  logic [3:0]  level;
  logic [15:0] div;
  logic [4:0]  fmt;
  int          num_errors, cmp_count, cycles;

  fpr_front_panel #(.SYSRST_HOLD(HOLD), .DEBOUNCE_LEN(18'd4),
    .LOCAL_HOLD(20'd8)) fpr_front_panel_i (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_abort_button_n(abort_n), .i_reset_button_n(btn_n),
    .i_watchdog_timeout(wdog), .i_sysreset_in_n(sys_n),
    .i_system_controller(ctl), .i_expansion_carrier(carrier),
    .i_board_fail_line_n(fail_n), .i_processor_bus_busy_n(busy_n),
    .i_pci_grant1_n(g1_n), .i_pci_grant2_n(g2_n),
    .o_sysreset_out(sys_out), .o_sysreset_oe(oe), .o_local_reset_n(loc_n),
    .o_processor_hard_reset_n(hard_n), .o_isa_irq8(irq8),
    .o_abort_level(level), .o_irq(irq), .o_board_fail_lamp(l_fail),
    .o_cpu_lamp(l_cpu), .o_mezzanine_slot1_lamp(l_s1),
    .o_mezzanine_slot2_lamp(l_s2), .o_uart_divisor(div),
    .o_uart_format(fmt));

  fpr_backplane fpr_backplane_i (.i_sysreset_oe(oe),
    .i_sysreset_out(sys_out), .i_other_assert(other), .o_sysreset_n(sys_n));

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = !i_mclk;
  end

  task report_and_stop;
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // setup, then access held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    do begin
      @(posedge i_mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task idle(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : idle

  // waits for the drive to start, then measures how long it stands
  task hold_check;
    int n, w;
    n = 0;
    w = 0;
    while (oe !== 1'b1 && w < 30) begin
      @(posedge i_mclk);
      w++;
    end
    chk(32'(oe), 32'h1);
    while (oe === 1'b1 && n < 400) begin
      @(posedge i_mclk);
      n++;
    end
    chk(32'(n >= int'(HOLD)), 32'h1);
    // own drive comes back on the wire, so local reset still stands here
    chk(32'({loc_n, hard_n}), 32'h0);
  endtask : hold_check

  task wait_rel;
    int n;
    n = 0;
    while (loc_n !== 1'b1 && n < 300) begin
      @(posedge i_mclk);
      n++;
    end
    chk(32'(loc_n), 32'h1);
  endtask : wait_rel

  task kick(input int s, input logic v);
    case (s)
      0: btn_n <= !v;
      1: wdog <= v;
      default: other <= v;
    endcase
  endtask : kick

  // one local reset source while not controller: this board leaves the wire undriven
  task local_src(input int s);
    oe_seen = 1'b0;
    @(posedge i_mclk);
    kick(s, 1'b1);
    idle(6);
    chk(32'({loc_n, hard_n}), 32'h0);
    kick(s, 1'b0);
    repeat (12) begin
      @(posedge i_mclk);
      oe_seen = oe_seen | oe;
    end
    chk(32'(oe_seen), 32'h0);
    wait_rel();
  endtask : local_src

  initial begin
    i_nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {abort_n, btn_n, fail_n, busy_n, g1_n, g2_n} = 6'h3f;
    {wdog, carrier, other} = 3'h0;
    ctl = 1'b1;
    idle(4);
    i_nrst <= 1'b1;
    hold_check();
    wait_rel();
    chk(32'(div), 32'h00a3);
    chk(32'(fmt), 32'h3);
    apb(1'b0, REG_UART, 32'h0);
    chk(rd, 32'h0003_00a3);
    apb(1'b1, REG_UART, 32'h0000_0051);
    apb(1'b0, REG_UART, 32'h0);
    chk(rd, 32'h0003_0051);
    chk(32'(div), 32'h0051);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // lamps follow their active-low lines
    @(posedge i_mclk);
    {fail_n, busy_n, g1_n, g2_n} <= 4'h0;
    idle(4);
    chk(32'({l_fail, l_cpu, l_s1, l_s2}), 32'hf);
    @(posedge i_mclk);
    {fail_n, busy_n, g1_n, g2_n} <= 4'ha;
    idle(4);
    chk(32'({l_fail, l_cpu, l_s1, l_s2}), 32'h5);
    @(posedge i_mclk);
    {fail_n, busy_n, g1_n, g2_n} <= 4'hf;
    carrier <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h40);
    idle(20);
    chk(32'({loc_n, l_s1, l_s2}), 32'h3);
    apb(1'b1, REG_CTRL, 32'h0);
    wait_rel();
    idle(4);
    chk(32'({l_s1, l_s2}), 32'h0);
    // abort: enable at level 5, glitch, press, hold, re-press
    apb(1'b0, REG_STAT, 32'h0);
    // only the power-up loop back of the wire has been seen so far
    chk(rd, 32'h0000_0002);
    apb(1'b1, REG_MASK, 32'h1);
    apb(1'b1, REG_CTRL, 32'h0000_000b);
    idle(2);
    chk(32'(level), 32'h5);
    @(posedge i_mclk);
    abort_n <= 1'b0;
    idle(2);
    abort_n <= 1'b1;
    idle(12);
    chk(32'(irq8), 32'h0);
    abort_n <= 1'b0;
    idle(12);
    chk(32'({irq8, irq}), 32'h3);
    apb(1'b0, REG_INPUTS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    apb(1'b1, REG_MASK, 32'h0);
    idle(2);
    chk(32'({irq8, irq}), 32'h2);
    apb(1'b0, REG_STAT, 32'h0);
    chk(rd & 32'h1, 32'h1);
    idle(14);
    chk(32'(irq8), 32'h0);
    abort_n <= 1'b1;
    idle(12);
    abort_n <= 1'b0;
    idle(12);
    chk(32'(irq8), 32'h1);
    abort_n <= 1'b1;
    apb(1'b0, REG_STAT, 32'h0);
    // controller: button, then software request, each holds the wire
    @(posedge i_mclk);
    btn_n <= 1'b0;
    idle(4);
    chk(32'({loc_n, hard_n}), 32'h0);
    btn_n <= 1'b1;
    hold_check();
    wait_rel();
    // button press and the looped-back wire are both pending
    apb(1'b0, REG_STAT, 32'h0);
    chk(rd, 32'h0000_000a);
    apb(1'b1, REG_CTRL, 32'h20);
    hold_check();
    wait_rel();
    // not controller: local reset still works from button, watchdog and incoming sysreset
    ctl <= 1'b0;
    idle(4);
    local_src(0);
    local_src(1);
    local_src(2);
    report_and_stop();
  end
endmodule : fpr_front_panel_test
